// *** clc_defines.svh ***
// Constants for the lookup control and cascade block
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH
// Widths of the address/control lines, page and active address
`define CLC_AC_W 13
`define CLC_PA_W 4
`define CLC_AA_W 16
// Configuration register fields
`define CLC_CFG_PAGE_LSB 0
`define CLC_CFG_WMASK_LSB 4
`define CLC_CFG_LOWEST_BIT 7
`define CLC_CFG_MODE_LSB 26
`define CLC_MODE_SW 2'h3
// Device select register fields
`define CLC_DSEL_VAL_LSB 0
`define CLC_DSEL_EN_N_BIT 4
// Software instruction fields on the data bus
`define CLC_SW_OP_LSB 0
`define CLC_SW_MSEL_LSB 6
`define CLC_SW_HALF_BIT 12
// Address/control field positions in control states
`define CLC_AC_MSEL_LSB 6
// Reset values
`define CLC_CFG_RST 32'h0000_0000
`define CLC_DSEL_RST 32'h0000_0010
// Control state codes
`define CLC_OP_CMPND 6'h00
`define CLC_OP_MASK 6'h01
`define CLC_OP_CFG 6'h02
`define CLC_OP_STATUS 6'h03
`define CLC_OP_ADDR 6'h04
`define CLC_OP_DSEL 6'h05
`define CLC_OP_MEM 6'h06
`define CLC_OP_COMPARE 6'h07
`define CLC_OP_ADVANCE 6'h08
`define CLC_OP_NFREE 6'h09
`define CLC_OP_INSTR 6'h0A
// Validation codes for the active address source
`define CLC_VC_NONE 2'h0
`define CLC_VC_CMP 2'h1
`define CLC_VC_RAND 2'h2
`define CLC_VC_NFREE 2'h3
`endif

// *** clc_pkg.sv ***
// Types shared by the lookup control and cascade block
`include "clc_defines.svh"
package clc_pkg;
   typedef enum logic [1:0] {CLC_IDLE = 2'b00, CLC_ACTIVE = 2'b01, CLC_RESULT = 2'b10} clc_phase_t;
   typedef enum logic [2:0] {
      CLC_A_NOP = 3'b000, CLC_A_READ = 3'b001, CLC_A_WRITE = 3'b010,
      CLC_A_COMPARE = 3'b011, CLC_A_ADVANCE = 3'b100, CLC_A_WRFREE = 3'b101
   } clc_arr_op_t;
   typedef struct packed {
      logic chip_en_n;
      logic select_first_n;
      logic select_second_n;
      logic write_n;
      logic out_en_n;
      logic addr_qualifier_n;
      logic word_half_select;
      logic [`CLC_AC_W-1:0] addr_ctrl_lines;
      logic entry_valid_n;
      logic [31:0] host_data_bus;
   } clc_host_in_t;
   typedef struct packed {
      logic wr_n;
      logic sel;
      logic av_n;
      logic [`CLC_AC_W-1:0] ac;
      logic half;
      logic vb_n;
      logic [31:0] data;
   } clc_cap_t;
   typedef struct packed {
      logic mem_rand;
      logic load_instr;
      logic [5:0] op;
      logic [2:0] msel;
      logic half;
   } clc_dec_t;
   typedef struct packed {
      logic valid;
      clc_arr_op_t op;
      logic [`CLC_AC_W-1:0] addr;
      logic half;
      logic [31:0] data;
      logic valid_n;
      logic [63:0] key;
      logic [63:0] mask;
   } clc_arr_cmd_t;
   typedef struct packed {
      logic hit;
      logic multi;
      logic [`CLC_AC_W-1:0] hit_addr;
      logic [`CLC_AC_W-1:0] free_addr;
      logic all_valid;
      logic [31:0] rd_data;
      logic rd_valid_n;
   } clc_arr_rsp_t;
   typedef struct packed {
      logic hit_flag_n;
      logic multi_oe;
      logic table_full_n;
   } clc_flags_t;
   typedef struct packed {
      clc_phase_t phase;
      logic ce_n_q;
      clc_cap_t cap;
      logic [31:0] cfg;
      logic [31:0] dsel;
      logic [`CLC_AC_W-1:0] addr_reg;
      logic [13:0] instr;
      logic [63:0] cmp;
      logic [6:0][63:0] masks;
      logic loc_hit;
      logic loc_multi;
      logic all_valid;
      logic [`CLC_AC_W-1:0] act;
      logic [1:0] vcode;
      logic rd_wait;
      logic [31:0] dout;
      logic doe;
      logic vb_out_n;
      logic vb_oe;
      logic [`CLC_PA_W-1:0] pa;
      logic [`CLC_AA_W-1:0] aa;
      logic aoe;
      clc_arr_cmd_t arr;
   } clc_state_t;
endpackage

// *** clc_cascade.sv ***
// Match, multiple-match and full daisy-chain flags
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_cascade (
   input wire logic mclk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic loc_hit, // Latched match in this device
   input wire logic loc_multi, // Latched two or more matches
   input wire logic all_valid, // Every location marked valid
   input wire logic hit_chain_in_n, // Match from higher priority
   input wire logic full_chain_in_n, // Full from higher priority
   output clc_pkg::clc_flags_t flags // Registered flag outputs
);
   import clc_pkg::*;
   clc_flags_t s_r;
   clc_flags_t s_nxt;

   // Flags are never gated by output enable; local terms only move after a cycle end
   always_comb begin
      s_nxt = s_r;
      s_nxt.hit_flag_n = ~(loc_hit | ~hit_chain_in_n);
      s_nxt.multi_oe = loc_multi | (loc_hit & ~hit_chain_in_n);
      s_nxt.table_full_n = ~(all_valid & ~full_chain_in_n);
   end

   // Reset shows no match and no multiple match
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '{hit_flag_n: 1'b1, multi_oe: 1'b0, table_full_n: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flags = s_r;
endmodule // clc_cascade

// *** clc_top.sv ***
// Control decode, address output and cascade glue of the lookup device
`timescale 1ns/1ps
`include "clc_defines.svh"
// Summary of operation
// - Qualifier low: lines address memory; high: lines carry a control state.
// - Random write stores the validity input level with the addressed entry.
// - Control states reach comparand, seven masks, config, status, address, select, instruction.
// - Config holds page, direct-write mask choice, hardware or software control.
// - Hardware control uses lines; software uses instruction register loaded from data.
// - Software control reaches memory only through the address register.
// - Either active-low chip select low selects the device.
// - Device select value equal to page with enable low also selects.
// - Output is page concatenated with match, next free or random address.
// - After compare only highest responder drives; output enable high floats.
// - System mismatch: lowest-priority device drives all ones.
// - Every memory read or write puts the accessed address on the output.
// - Output changes only while chip enable high, latched while low.
// - Match flags update after chip enable rises in a compare, then persist.
// - Deselected device during a compare clears its match, shows mismatch.
// - Status reports address, match, full, multiple flags and two validation bits.
// - Match flag feeds next device match input; last gives system match.
// - Multiple-match pulls low on two matches or match with chain low.
// - Advance state resets highest match latch to reach further matches.
// - Full flag feeds next device and changes only after a compare, advance or memory write cycle.
// - Match and full chain outputs are not gated by output enable.
// - Match flag low when chain input low, else only on own match.
// - Full flag low only with all entries valid and full input low.
// - Chip enable falling captures controls, and on writes validity and data.
module clc_top (
   input wire logic mclk, // System clock, 200 MHz
   input wire logic reset, // Synchronous reset, high
   input clc_pkg::clc_host_in_t host, // Host control bus and data in
   input wire logic hit_chain_in_n, // Match chain from higher device
   input wire logic full_chain_in_n, // Full chain from higher device
   output logic [31:0] host_data_out, // Data bus drive value
   output logic host_data_oe, // Data bus drive enable
   output logic entry_valid_out_n, // Validity read back
   output logic entry_valid_oe, // Validity drive enable
   output logic [`CLC_PA_W-1:0] page_out, // Page part of address out
   output logic [`CLC_AA_W-1:0] active_addr_out, // Active address out
   output logic addr_oe, // Page and active address enable
   output logic hit_flag_n, // Match flag chain out
   output logic multi_hit_out_n, // Open-drain level, always low
   output logic multi_hit_oe, // Pulls the wired multi-match low
   output logic table_full_n, // Full flag chain out
   output clc_pkg::clc_arr_cmd_t arr_cmd, // Command to the compare array
   input clc_pkg::clc_arr_rsp_t arr_rsp // Answer from the compare array
);
   import clc_pkg::*;

   clc_state_t s_r;
   clc_state_t s_nxt;
   clc_flags_t flags;
   clc_cap_t cap_now;
   clc_dec_t dec_now;
   clc_dec_t dec_q;
   logic sel_now;
   logic ce_fall;
   logic ce_rise;
   logic sw_mode;
   logic [31:0] status_w;

   // Turn captured lines into a control state for either control mode
   function automatic clc_dec_t clc_decode(input clc_cap_t c, input logic [31:0] cfg,
                                           input logic [13:0] ins);
      clc_dec_t d;
      d = '0;
      if (cfg[`CLC_CFG_MODE_LSB +: 2] != `CLC_MODE_SW) begin
         d.half = c.half;
         if (!c.av_n) begin
            d.mem_rand = 1'b1;
         end else begin
            d.op = c.ac[5:0];
            d.msel = c.ac[`CLC_AC_MSEL_LSB +: 3];
         end
      end else if (c.av_n) begin
         if (c.wr_n) begin
            d.op = `CLC_OP_STATUS;
         end else begin
            d.load_instr = 1'b1;
            d.op = c.data[`CLC_SW_OP_LSB +: 6];
            d.msel = c.data[`CLC_SW_MSEL_LSB +: 3];
            d.half = c.data[`CLC_SW_HALF_BIT];
         end
      end else begin
         // No direct addressing here: memory goes through the address register
         d.op = ins[`CLC_SW_OP_LSB +: 6];
         d.msel = ins[`CLC_SW_MSEL_LSB +: 3];
         d.half = ins[`CLC_SW_HALF_BIT];
      end
      return d;
   endfunction

   // Lines as they would be captured on a falling chip enable
   always_comb begin
      cap_now.wr_n = host.write_n;
      cap_now.sel = sel_now;
      cap_now.av_n = host.addr_qualifier_n;
      cap_now.ac = host.addr_ctrl_lines;
      cap_now.half = host.word_half_select;
      cap_now.vb_n = host.entry_valid_n;
      cap_now.data = host.host_data_bus;
   end

   // Chip selects and the register select work in parallel
   assign sel_now = ~host.select_first_n | ~host.select_second_n
      | (~s_r.dsel[`CLC_DSEL_EN_N_BIT]
         & (s_r.dsel[`CLC_DSEL_VAL_LSB +: `CLC_PA_W]
            == s_r.cfg[`CLC_CFG_PAGE_LSB +: `CLC_PA_W]));
   assign ce_fall = s_r.ce_n_q & ~host.chip_en_n;
   assign ce_rise = ~s_r.ce_n_q & host.chip_en_n;
   assign sw_mode = (s_r.cfg[`CLC_CFG_MODE_LSB +: 2] == `CLC_MODE_SW);
   assign dec_now = clc_decode(cap_now, s_r.cfg, s_r.instr);
   assign dec_q = clc_decode(s_r.cap, s_r.cfg, s_r.instr);

   // Status word: validation code, flags, page and active address
   assign status_w = {6'h00, s_r.vcode, 1'b0, flags.table_full_n, ~flags.multi_oe,
                      flags.hit_flag_n, s_r.pa, s_r.aa};

   // Main sequencing: capture on the falling edge, act on the rising edge
   always_comb begin
      logic mem_op;
      logic [`CLC_AC_W-1:0] maddr;
      logic [2:0] mi;
      logic drive_ok;
      logic ones;
      mem_op = 1'b0;
      maddr = '0;
      mi = '0;
      drive_ok = 1'b0;
      ones = 1'b0;
      s_nxt = s_r;
      s_nxt.ce_n_q = host.chip_en_n;
      s_nxt.arr.valid = 1'b0;
      s_nxt.arr.op = CLC_A_NOP;

      // Falling edge registers the control lines
      if (ce_fall) begin
         s_nxt.cap = cap_now;
         s_nxt.phase = CLC_ACTIVE;
         mem_op = dec_now.mem_rand | (dec_now.op == `CLC_OP_MEM);
         maddr = dec_now.mem_rand ? host.addr_ctrl_lines : s_r.addr_reg;
         mi = 3'(dec_now.msel - 3'h1);
         if (host.write_n && sel_now) begin
            if (mem_op) begin
               // Array read answers a cycle later; data drives then
               s_nxt.arr.valid = 1'b1;
               s_nxt.arr.op = CLC_A_READ;
               s_nxt.arr.addr = maddr;
               s_nxt.arr.half = dec_now.half;
               s_nxt.rd_wait = 1'b1;
            end else begin
               s_nxt.doe = 1'b1;
               case (dec_now.op)
                  `CLC_OP_CMPND: s_nxt.dout = dec_now.half ? s_r.cmp[63:32] : s_r.cmp[31:0];
                  `CLC_OP_MASK: begin
                     if (dec_now.msel == 3'h0) begin
                        s_nxt.dout = 32'h0000_0000;
                     end else begin
                        s_nxt.dout = dec_now.half ? s_r.masks[mi][63:32] : s_r.masks[mi][31:0];
                     end
                  end
                  `CLC_OP_CFG: s_nxt.dout = s_r.cfg;
                  `CLC_OP_ADDR: s_nxt.dout = 32'(s_r.addr_reg);
                  `CLC_OP_DSEL: s_nxt.dout = s_r.dsel;
                  `CLC_OP_INSTR: s_nxt.dout = 32'(s_r.instr);
                  default: s_nxt.dout = status_w;
               endcase
            end
         end
      end

      // Array read data arrives while chip enable is still low
      if (s_r.rd_wait && !ce_rise) begin
         s_nxt.rd_wait = 1'b0;
         s_nxt.dout = arr_rsp.rd_data;
         s_nxt.doe = 1'b1;
         s_nxt.vb_out_n = arr_rsp.rd_valid_n;
         s_nxt.vb_oe = 1'b1;
      end

      // Rising edge ends the cycle and executes it
      if (ce_rise) begin
         s_nxt.phase = CLC_IDLE;
         s_nxt.doe = 1'b0;
         s_nxt.vb_oe = 1'b0;
         s_nxt.rd_wait = 1'b0;
         mem_op = dec_q.mem_rand | (dec_q.op == `CLC_OP_MEM);
         maddr = dec_q.mem_rand ? s_r.cap.ac : s_r.addr_reg;
         mi = 3'(dec_q.msel - 3'h1);
         if (dec_q.load_instr && s_r.cap.sel) begin
            s_nxt.instr = s_r.cap.data[13:0];
         end
         if (dec_q.op == `CLC_OP_COMPARE && !s_r.cap.wr_n && !dec_q.load_instr) begin
            if (s_r.cap.sel) begin
               if (dec_q.half) begin
                  s_nxt.cmp[63:32] = s_r.cap.data;
               end else begin
                  s_nxt.cmp[31:0] = s_r.cap.data;
               end
               s_nxt.arr.valid = 1'b1;
               s_nxt.arr.op = CLC_A_COMPARE;
               s_nxt.arr.key = s_nxt.cmp;
               s_nxt.arr.mask = (dec_q.msel == 3'h0) ? 64'h0 : s_r.masks[mi];
               s_nxt.phase = CLC_RESULT;
            end else begin
               // Not selected: earlier match is dropped
               s_nxt.loc_hit = 1'b0;
               s_nxt.loc_multi = 1'b0;
               s_nxt.vcode = `CLC_VC_CMP;
            end
         end else if (s_r.cap.sel && dec_q.op == `CLC_OP_ADVANCE && !dec_q.mem_rand) begin
            // Drops the top match so the next one becomes highest
            s_nxt.arr.valid = 1'b1;
            s_nxt.arr.op = CLC_A_ADVANCE;
            s_nxt.phase = CLC_RESULT;
         end else if (s_r.cap.sel && !dec_q.load_instr && mem_op) begin
            s_nxt.act = maddr;
            s_nxt.vcode = `CLC_VC_RAND;
            if (!s_r.cap.wr_n) begin
               s_nxt.arr.valid = 1'b1;
               s_nxt.arr.op = CLC_A_WRITE;
               s_nxt.arr.addr = maddr;
               s_nxt.arr.half = dec_q.half;
               s_nxt.arr.data = s_r.cap.data;
               s_nxt.arr.valid_n = s_r.cap.vb_n;
               s_nxt.arr.mask = s_r.masks[3'(s_r.cfg[`CLC_CFG_WMASK_LSB +: 3] - 3'h1)];
               if (s_r.cfg[`CLC_CFG_WMASK_LSB +: 3] == 3'h0) begin
                  s_nxt.arr.mask = 64'h0;
               end
               s_nxt.phase = CLC_RESULT;
            end
         end else if (s_r.cap.sel && !s_r.cap.wr_n && !dec_q.load_instr) begin
            case (dec_q.op)
               `CLC_OP_CMPND: begin
                  if (dec_q.half) begin
                     s_nxt.cmp[63:32] = s_r.cap.data;
                  end else begin
                     s_nxt.cmp[31:0] = s_r.cap.data;
                  end
               end
               `CLC_OP_MASK: begin
                  if (dec_q.msel != 3'h0 && dec_q.half) begin
                     s_nxt.masks[mi][63:32] = s_r.cap.data;
                  end else if (dec_q.msel != 3'h0) begin
                     s_nxt.masks[mi][31:0] = s_r.cap.data;
                  end
               end
               `CLC_OP_CFG: s_nxt.cfg = s_r.cap.data;
               `CLC_OP_ADDR: s_nxt.addr_reg = s_r.cap.data[`CLC_AC_W-1:0];
               `CLC_OP_DSEL: s_nxt.dsel = s_r.cap.data;
               `CLC_OP_NFREE: begin
                  s_nxt.arr.valid = 1'b1;
                  s_nxt.arr.op = CLC_A_WRFREE;
                  s_nxt.arr.addr = arr_rsp.free_addr;
                  s_nxt.arr.data = s_r.cap.data;
                  s_nxt.arr.half = dec_q.half;
                  s_nxt.arr.valid_n = s_r.cap.vb_n;
                  s_nxt.act = arr_rsp.free_addr;
                  s_nxt.vcode = `CLC_VC_NFREE;
                  s_nxt.phase = CLC_RESULT;
               end
               default: s_nxt.instr = s_r.instr;
            endcase
         end
      end

      // Array answers while the command stands, one cycle after chip enable rose
      if (s_r.phase == CLC_RESULT) begin
         s_nxt.phase = CLC_IDLE;
         s_nxt.all_valid = arr_rsp.all_valid;
         if (s_r.arr.op == CLC_A_COMPARE || s_r.arr.op == CLC_A_ADVANCE) begin
            s_nxt.loc_hit = arr_rsp.hit;
            s_nxt.loc_multi = arr_rsp.multi;
            s_nxt.act = arr_rsp.hit_addr;
            s_nxt.vcode = `CLC_VC_CMP;
         end
      end

      // Who may drive the address output, and with what
      case (s_r.vcode)
         `CLC_VC_CMP: begin
            drive_ok = hit_chain_in_n
               & (s_r.loc_hit | s_r.cfg[`CLC_CFG_LOWEST_BIT]);
            ones = ~s_r.loc_hit;
         end
         `CLC_VC_RAND, `CLC_VC_NFREE: drive_ok = 1'b1;
         default: drive_ok = 1'b0;
      endcase
      s_nxt.aoe = drive_ok & ~host.out_en_n;

      // Value only moves while chip enable is high, so it stays latched while low
      if (host.chip_en_n && s_r.ce_n_q) begin
         s_nxt.pa = ones ? {`CLC_PA_W{1'b1}} : s_r.cfg[`CLC_CFG_PAGE_LSB +: `CLC_PA_W];
         s_nxt.aa = ones ? {`CLC_AA_W{1'b1}} : `CLC_AA_W'(s_r.act);
      end
   end

   // Single state register
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '0;
         s_r.ce_n_q <= 1'b1;
         s_r.cfg <= `CLC_CFG_RST;
         s_r.dsel <= `CLC_DSEL_RST;
         s_r.vb_out_n <= 1'b1;
         s_r.vcode <= `CLC_VC_NONE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Daisy chains and open-drain multi-match
   clc_cascade u_cascade (
      .mclk(mclk),
      .reset(reset),
      .loc_hit(s_r.loc_hit),
      .loc_multi(s_r.loc_multi),
      .all_valid(s_r.all_valid),
      .hit_chain_in_n(hit_chain_in_n),
      .full_chain_in_n(full_chain_in_n),
      .flags(flags)
   );

   // Outputs straight from state flops; the multi-match level is a constant low
   assign host_data_out = s_r.dout;
   assign host_data_oe = s_r.doe;
   assign entry_valid_out_n = s_r.vb_out_n;
   assign entry_valid_oe = s_r.vb_oe;
   assign page_out = s_r.pa;
   assign active_addr_out = s_r.aa;
   assign addr_oe = s_r.aoe;
   assign hit_flag_n = flags.hit_flag_n;
   assign multi_hit_out_n = 1'b0;
   assign multi_hit_oe = flags.multi_oe;
   assign table_full_n = flags.table_full_n;
   assign arr_cmd = s_r.arr;
endmodule // clc_top

// *** clc_top_properties.sv ***
// Port-level assertions for the lookup control and cascade block
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_top_properties import clc_pkg::*; (
   input wire logic mclk, // Clock
   input wire logic reset, // Sync reset
   input clc_pkg::clc_host_in_t host, // Host bus
   input wire logic hit_chain_in_n, // Match chain in
   input wire logic full_chain_in_n, // Full chain in
   input wire logic [`CLC_PA_W-1:0] page_out, // Page out
   input wire logic [`CLC_AA_W-1:0] active_addr_out, // Address out
   input wire logic addr_oe, // Address enable
   input wire logic hit_flag_n, // Match flag
   input wire logic multi_hit_out_n, // Open-drain value
   input wire logic multi_hit_oe, // Multi pull enable
   input wire logic table_full_n // Full flag
);
   logic ce_q_r;
   logic [3:0] since_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Cycles since chip enable rose; flags may only move shortly after one
   always_ff @(posedge mclk) begin
      ce_q_r <= host.chip_en_n;
      if (reset || (host.chip_en_n && !ce_q_r)) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
   end
   property p_full_low; !table_full_n |-> !$past(full_chain_in_n); endproperty
   a_full_low: assert property (p_full_low) else $error("full flag low with chain high");
   property p_chain; !hit_chain_in_n |=> !hit_flag_n; endproperty
   a_chain: assert property (p_chain) else $error("match flag ignores chain");
   property p_ungated; !hit_chain_in_n && host.out_en_n |=> !hit_flag_n; endproperty
   a_ungated: assert property (p_ungated) else $error("match chain gated by enable");
   property p_multi; hit_flag_n |-> !multi_hit_oe && !multi_hit_out_n; endproperty
   a_multi: assert property (p_multi) else $error("multi pull without match");
   property p_rst; $fell(reset) |-> hit_flag_n && table_full_n && !multi_hit_oe && !addr_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("flags not idle after reset");
   property p_oe; $past(host.out_en_n) |-> !addr_oe; endproperty
   a_oe: assert property (p_oe) else $error("address driven with enable high");
   property p_hold;
      $changed({page_out, active_addr_out}) |-> $past(host.chip_en_n) && $past(host.chip_en_n, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved while enable low");
   property p_hit_upd;
      $changed(hit_flag_n) |-> since_r < 4'h6 || $past(hit_chain_in_n) != $past(hit_chain_in_n, 2);
   endproperty
   a_hit_upd: assert property (p_hit_upd) else $error("match flag moved outside a cycle");
   property p_full_upd;
      $changed(table_full_n) |-> since_r < 4'h8 || $past(full_chain_in_n) != $past(full_chain_in_n, 2);
   endproperty
   a_full_upd: assert property (p_full_upd) else $error("full flag moved outside a cycle");
endmodule // clc_top_properties
bind clc_top clc_top_properties clc_top_properties_i (.mclk(mclk), .reset(reset), .host(host),
   .hit_chain_in_n(hit_chain_in_n), .full_chain_in_n(full_chain_in_n), .page_out(page_out),
   .active_addr_out(active_addr_out), .addr_oe(addr_oe), .hit_flag_n(hit_flag_n),
   .multi_hit_out_n(multi_hit_out_n), .multi_hit_oe(multi_hit_oe), .table_full_n(table_full_n));

// *** clc_array_model.sv ***
// Behavioural compare array answering the block's commands
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_array_model import clc_pkg::*; (
   input wire logic mclk, // Clock
   input clc_pkg::clc_arr_cmd_t cmd, // Command from the block
   input wire logic [1:0] n_hit, // Matches the next compare finds
   input wire logic full, // Every entry valid
   output clc_pkg::clc_arr_rsp_t rsp, // Answer levels
   output clc_pkg::clc_arr_cmd_t last_r // Last command seen
);
   logic [1:0] left_r = 2'h0;
   logic [31:0] word_r = 32'h0;
   logic vb_r = 1'b1;
   logic [1:0] cnt;
   // Answer at once, since the block samples while the command pulse stands
   always_comb begin
      cnt = left_r;
      if (cmd.valid && cmd.op == CLC_A_COMPARE) cnt = n_hit;
      if (cmd.valid && cmd.op == CLC_A_ADVANCE && left_r != 2'h0) cnt = left_r - 2'h1;
      rsp = '0;
      rsp.hit = cnt != 2'h0;
      rsp.multi = cnt > 2'h1;
      rsp.hit_addr = {11'h010, cnt};
      rsp.free_addr = 13'h0007;
      rsp.all_valid = full;
      rsp.rd_data = word_r;
      rsp.rd_valid_n = vb_r;
   end
   // One stored word; reads return it with its validity
   always_ff @(posedge mclk) begin
      if (cmd.valid) begin
         last_r <= cmd;
         left_r <= cnt;
         if (cmd.op == CLC_A_WRITE) begin
            word_r <= cmd.data;
            vb_r <= cmd.valid_n;
         end
      end
   end
endmodule // clc_array_model

// *** clc_top_tb_top.sv ***
// Self-checking bench for the lookup control and cascade block
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_top_tb_top;
   import clc_pkg::*;
   logic mclk, reset, mi_n, fi_n, full, dv, vb_o, aoe, hf_n, mm_n, mm_oe, ff_n;
   logic [1:0] n_hit, oe_s, oe_q;
   logic [31:0] dq, dout;
   logic [3:0] pa;
   logic [15:0] aa;
   int n_mismatch = 0;
   int comparisons = 0;
   clc_host_in_t host;
   clc_arr_cmd_t cmd, last;
   clc_arr_rsp_t rsp;
   clc_top clc_top_i (.mclk(mclk), .reset(reset), .host(host), .hit_chain_in_n(mi_n),
      .full_chain_in_n(fi_n), .host_data_out(dout), .host_data_oe(oe_s[1]),
      .entry_valid_out_n(vb_o), .entry_valid_oe(oe_s[0]), .page_out(pa), .active_addr_out(aa),
      .addr_oe(aoe), .hit_flag_n(hf_n), .multi_hit_out_n(mm_n), .multi_hit_oe(mm_oe),
      .table_full_n(ff_n), .arr_cmd(cmd), .arr_rsp(rsp));
   clc_array_model clc_array_model_i (.mclk(mclk), .cmd(cmd), .n_hit(n_hit), .full(full),
      .rsp(rsp), .last_r(last));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One host cycle; read data taken while the enable still stands
   task automatic cyc(input logic w_n, input logic av_n, input logic [12:0] ac,
         input logic [31:0] d, input logic vb_n);
      wt(1);
      host.write_n = w_n;
      host.addr_qualifier_n = av_n;
      host.addr_ctrl_lines = ac;
      host.host_data_bus = d;
      host.entry_valid_n = vb_n;
      host.chip_en_n = 1'b0;
      wt(3);
      dq = dout;
      oe_q = oe_s;
      dv = vb_o;
      host.chip_en_n = 1'b1;
      wt(6);
   endtask
   task automatic test_done();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog, well beyond the under two hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      test_done();
   end
   initial begin
      host = '1;
      host.select_first_n = 1'b0;
      host.word_half_select = 1'b0;
      {reset, mi_n, fi_n, full, n_hit} = 6'h38;
      wt(10);
      reset = 1'b0;
      chk(32'({mm_n, hf_n, mm_oe, aoe, ff_n}), 32'h09);
      // Random write, then read back
      cyc(1'b0, 1'b0, 13'h0123, 32'hA5A5_0F0F, 1'b0);
      chk(32'(last.op), 32'(CLC_A_WRITE));
      chk(32'(last.addr), 32'h0123);
      chk(32'(last.valid_n), 32'h0);
      chk(last.data, 32'hA5A5_0F0F);
      host.out_en_n = 1'b0;
      wt(2);
      chk(32'({aoe, pa, aa}), 32'h0010_0123);
      cyc(1'b1, 1'b0, 13'h0123, 32'h0, 1'b1);
      chk(dq, 32'hA5A5_0F0F);
      chk(32'(dv), 32'h0);
      chk(32'(oe_q), 32'h3);
      // Page 5, lowest priority; mismatch then a double hit
      cyc(1'b0, 1'b1, 13'h0002, 32'h0000_0085, 1'b1);
      cyc(1'b0, 1'b1, 13'h0007, 32'h1357_9BDF, 1'b1);
      chk(32'(last.key[31:0]), 32'h1357_9BDF);
      chk(32'({hf_n, pa, aa}), 32'h001F_FFFF);
      host.out_en_n = 1'b1;
      n_hit = 2'h2;
      cyc(1'b0, 1'b1, 13'h0007, 32'h1357_9BDF, 1'b1);
      chk(32'({hf_n, mm_oe, aoe}), 32'h2);
      host.out_en_n = 1'b0;
      wt(1);
      chk(32'({aoe, pa, aa}), 32'h0015_0042);
      cyc(1'b1, 1'b1, 13'h0003, 32'h0, 1'b1);
      chk(dq & 32'h037F_FFFF, 32'h0145_0042);
      cyc(1'b0, 1'b1, 13'h0008, 32'h0, 1'b1);
      chk(32'(last.op), 32'(CLC_A_ADVANCE));
      chk(32'({mm_oe, pa, aa}), 32'h0005_0041);
      // Chain input low: this device is no longer highest
      mi_n = 1'b0;
      wt(2);
      chk(32'({hf_n, mm_oe, aoe}), 32'h2);
      mi_n = 1'b1;
      // Deselected compare clears; select register then selects
      host.select_first_n = 1'b1;
      n_hit = 2'h1;
      cyc(1'b0, 1'b1, 13'h0007, 32'h0, 1'b1);
      chk(32'(hf_n), 32'h1);
      host.select_second_n = 1'b0;
      cyc(1'b0, 1'b1, 13'h0005, 32'h0000_0005, 1'b1);
      host.select_second_n = 1'b1;
      cyc(1'b0, 1'b1, 13'h0007, 32'h0, 1'b1);
      chk(32'(hf_n), 32'h0);
      cyc(1'b0, 1'b1, 13'h0005, 32'h0000_0010, 1'b1);
      host.select_second_n = 1'b0;
      // Last entry written valid with full chain low
      {full, fi_n} = 2'h2;
      cyc(1'b0, 1'b0, 13'h1ABC, 32'h0, 1'b0);
      chk(32'({ff_n, pa, aa}), 32'h0005_1ABC);
      fi_n = 1'b1;
      wt(2);
      chk(32'(ff_n), 32'h1);
      // Software control: memory only through the address register
      cyc(1'b0, 1'b1, 13'h0004, 32'h0000_0055, 1'b1);
      cyc(1'b0, 1'b1, 13'h0002, 32'h0C00_0085, 1'b1);
      cyc(1'b0, 1'b1, 13'h1FFF, 32'h0000_0006, 1'b1);
      cyc(1'b0, 1'b0, 13'h0777, 32'h1234_5678, 1'b0);
      chk(32'(last.addr), 32'h0055);
      chk(last.data, 32'h1234_5678);
      test_done();
   end
endmodule // clc_top_tb_top
